// ===== design/pin_mux_pkg.sv
// constants shared by the port and system bus pin multiplexer
`default_nettype none
package pin_mux_pkg;
	// port widths
	localparam int D_W = 8;
	localparam int G_W = 5;
	localparam int J_W = 8;
	localparam int ADDR_W = 12;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_D_PINS = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_D_LAT = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_D_DIR = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_G_PINS = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_G_LAT = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_G_DIR = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_J_PINS = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_J_LAT = 12'h01c;
	localparam logic [ADDR_W-1:0] OFF_J_DIR = 12'h020;
	localparam logic [ADDR_W-1:0] OFF_BUS_CTRL = 12'h024;
	// external_bus_control fields
	localparam int EBC_DISABLE_BIT = 7;
	localparam int EBC_PGM_SEL_BIT = 6;
	localparam int EBC_WAIT_LSB = 4;
	localparam int EBC_WM_LSB = 0;
	localparam logic [7:0] EBC_WRITE_MASK = 8'hf3;
	localparam logic [7:0] EBC_RESET = 8'h00;
	// control_signal_port bit roles
	localparam int CTL_ALE_BIT = 0;
	localparam int CTL_OE_BIT = 1;
	localparam int CTL_WRL_BIT = 2;
	localparam int CTL_WRH_BIT = 3;
	localparam int CTL_BA0_BIT = 4;
	// reset values of latch and direction
	localparam logic [7:0] LAT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hff;
endpackage : pin_mux_pkg
`default_nettype wire

// ===== design/port_regs_if.sv
// register strobes and readback between the bus slave and one port
`default_nettype none
interface port_regs_if #(parameter int W = 8);
	logic wr_latch;
	logic wr_dir;
	logic [W-1:0] wdata;
	logic [W-1:0] latch;
	logic [W-1:0] dir;
	logic [W-1:0] level;
	modport ctrl (output wr_latch, output wr_dir, output wdata, input latch, input dir, input level);
	modport port (input wr_latch, input wr_dir, input wdata, output latch, output dir, output level);
endinterface : port_regs_if
`default_nettype wire

// ===== design/pin_sync.sv
// three-stage pin synchroniser, a change counts once stages two and three agree
`default_nettype none
module pin_sync #(parameter int W = 8) (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic [W-1:0] pin_in, // raw pin levels
	output logic [W-1:0] level // filtered levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} state_type;
	state_type q, d;

	// stage one feeds only stage two
	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
endmodule : pin_sync
`default_nettype wire

// ===== design/io_port.sv
// one bidirectional port: latch, direction and bus/io output select
`default_nettype none
module io_port
	import pin_mux_pkg::*;
#(parameter int W = 8) (
	input wire logic clk, // core clock
	input wire logic rstn, // power-on / brown-out reset, active low
	input wire logic other_reset, // any other reset, sync, active high
	port_regs_if.port regs, // register strobes and readback
	input wire logic [W-1:0] bus_sel, // 1 = pin serves the system bus
	input wire logic [W-1:0] bus_out, // bus value to drive
	input wire logic [W-1:0] bus_oe, // bus wants to drive
	input wire logic [W-1:0] pin_in, // pin level
	output logic [W-1:0] pin_out, // pin drive value
	output logic [W-1:0] pin_oe_n // low while driving the pin
);
	typedef struct packed {
		logic [W-1:0] lat;
		logic [W-1:0] dir;
		logic [W-1:0] out;
		logic [W-1:0] oe_n;
	} state_type;
	state_type q, d;

	pin_sync #(.W(W)) sync_i (
		.clk(clk),
		.rstn(rstn),
		.pin_in(pin_in),
		.level(regs.level)
	);

	// bus function never touches latch or direction, so io state survives
	always_comb begin
		d = q;
		if (regs.wr_latch) begin
			d.lat = regs.wdata;
		end
		if (other_reset) begin
			d.dir = '1;
		end else if (regs.wr_dir) begin
			d.dir = regs.wdata;
		end
		d.out = (bus_sel & bus_out) | (~bus_sel & q.lat);
		d.oe_n = (bus_sel & ~bus_oe) | (~bus_sel & q.dir);
	end

	// latch is left alone by other resets
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q.lat <= LAT_RESET[W-1:0];
			q.dir <= DIR_RESET[W-1:0];
			q.out <= '0;
			q.oe_n <= '1;
		end else begin
			q <= d;
		end
	end

	assign regs.latch = q.lat;
	assign regs.dir = q.dir;
	assign pin_out = q.out;
	assign pin_oe_n = q.oe_n;

	chk_dir_sets_oe: assert property (@(posedge clk) disable iff (!rstn)
		rstn |=> ((pin_oe_n & ~$past(bus_sel)) == ($past(q.dir) & ~$past(bus_sel))))
		else $error("io pin enable does not follow direction");
	chk_latch_on_pin: assert property (@(posedge clk) disable iff (!rstn)
		rstn |=> ((pin_out & ~$past(bus_sel)) == ($past(q.lat) & ~$past(bus_sel))))
		else $error("io pin value does not follow latch");
	chk_bus_on_pin: assert property (@(posedge clk) disable iff (!rstn)
		rstn |=> ((pin_out & $past(bus_sel)) == ($past(bus_out) & $past(bus_sel))))
		else $error("bus pin value not from bus");
	chk_latch_holds: assert property (@(posedge clk) disable iff (!rstn)
		!regs.wr_latch |=> $stable(q.lat))
		else $error("latch changed without a write");
	chk_other_reset_dir: assert property (@(posedge clk) disable iff (!rstn)
		other_reset |=> (q.dir == '1))
		else $error("direction not all ones after reset");
endmodule : io_port
`default_nettype wire

// ===== design/port_bus_pin_mux.sv
// apb register slave and pin function selection for the three bus ports
//
// Local design decisions: the APB slave port and the register addresses.
`default_nettype none
module port_bus_pin_mux
	import pin_mux_pkg::*;
(
	input wire logic pclk, // core clock, 10 MHz
	input wire logic presetn, // power-on / brown-out reset
	input wire logic other_reset, // any other reset, sync, active high
	input wire logic [ADDR_W-1:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic bus_8bit_mode, // 1 = 8-bit bus mode
	input wire logic exec_internal, // 1 = running from internal program ram
	input wire logic [D_W-1:0] bus_ad_out, // address/data from bus engine
	input wire logic bus_ad_oe, // bus engine drives address/data
	input wire logic [G_W-1:0] bus_ctl_out, // bus control strobes
	input wire logic [J_W-1:0] bus_data_out, // data from bus engine
	input wire logic bus_data_oe, // bus engine drives data
	output logic [D_W-1:0] bus_ad_in, // filtered address/data pin levels
	output logic [J_W-1:0] bus_data_in, // filtered data pin levels
	output logic program_select_bit, // memory control field
	output logic [1:0] wait_states, // memory control field
	output logic [1:0] write_mode_select, // memory control field
	input wire logic [D_W-1:0] ad_pin_in, // addr_data_port pins in
	output logic [D_W-1:0] ad_pin_out, // addr_data_port pins out
	output logic [D_W-1:0] ad_pin_oe_n, // addr_data_port enables
	input wire logic [G_W-1:0] ctl_pin_in, // control_signal_port pins in
	output logic [G_W-1:0] ctl_pin_out, // control_signal_port pins out
	output logic [G_W-1:0] ctl_pin_oe_n, // control_signal_port enables
	input wire logic [J_W-1:0] db_pin_in, // data_bus_port pins in
	output logic [J_W-1:0] db_pin_out, // data_bus_port pins out
	output logic [J_W-1:0] db_pin_oe_n // data_bus_port enables
);
	typedef struct packed {
		logic [7:0] ebc;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} state_type;
	state_type q, d;

	port_regs_if #(.W(D_W)) d_if ();
	port_regs_if #(.W(G_W)) g_if ();
	port_regs_if #(.W(J_W)) j_if ();

	logic bus_on;
	logic wrh_io;
	logic [D_W-1:0] d_sel;
	logic [G_W-1:0] g_sel;
	logic [J_W-1:0] j_sel;
	logic access;
	logic wr_ok;
	logic mapped;
	logic [31:0] rd_mux;

	// function select: bus owns pins unless disabled while running internally, data port only in 8-bit mode, wrh pin freed in 8-bit external mode
	always_comb begin
		bus_on = !(q.ebc[EBC_DISABLE_BIT] && exec_internal);
		wrh_io = bus_8bit_mode && !exec_internal;
		d_sel = {D_W{bus_on}};
		j_sel = {J_W{bus_on && bus_8bit_mode}};
		g_sel = {G_W{bus_on}} & ~(G_W'(wrh_io) << CTL_WRH_BIT);
	end

	// apb decode; one wait state gives a registered read path
	always_comb begin
		access = psel && penable;
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFF_D_PINS: rd_mux = 32'(d_if.level);
			OFF_D_LAT: rd_mux = 32'(d_if.latch);
			OFF_D_DIR: rd_mux = 32'(d_if.dir);
			OFF_G_PINS: rd_mux = 32'(g_if.level);
			OFF_G_LAT: rd_mux = 32'(g_if.latch);
			OFF_G_DIR: rd_mux = 32'(g_if.dir);
			OFF_J_PINS: rd_mux = 32'(j_if.level);
			OFF_J_LAT: rd_mux = 32'(j_if.latch);
			OFF_J_DIR: rd_mux = 32'(j_if.dir);
			OFF_BUS_CTRL: rd_mux = 32'(q.ebc);
			default: mapped = 1'b0;
		endcase
		wr_ok = access && pwrite && q.ready && mapped;
	end

	// register strobes towards the ports, taken at the edge pready is high
	always_comb begin
		d_if.wr_latch = wr_ok && (paddr == OFF_D_PINS || paddr == OFF_D_LAT);
		d_if.wr_dir = wr_ok && (paddr == OFF_D_DIR);
		d_if.wdata = pwdata[D_W-1:0];
		g_if.wr_latch = wr_ok && (paddr == OFF_G_PINS || paddr == OFF_G_LAT);
		g_if.wr_dir = wr_ok && (paddr == OFF_G_DIR);
		g_if.wdata = pwdata[G_W-1:0];
		j_if.wr_latch = wr_ok && (paddr == OFF_J_PINS || paddr == OFF_J_LAT);
		j_if.wr_dir = wr_ok && (paddr == OFF_J_DIR);
		j_if.wdata = pwdata[J_W-1:0];
	end

	// next state of the slave and the bus control register
	always_comb begin
		d = q;
		d.ready = access && !q.ready;
		if (access && !q.ready) begin
			d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
			d.err = !mapped;
		end else begin
			d.err = 1'b0;
		end
		if (other_reset) begin
			d.ebc = EBC_RESET;
		end else if (wr_ok && paddr == OFF_BUS_CTRL) begin
			d.ebc = pwdata[7:0] & EBC_WRITE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.ebc <= EBC_RESET;
			q.rdata <= 32'h0000_0000;
			q.ready <= 1'b0;
			q.err <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// address/data port, bus bit n on pin n
	io_port #(.W(D_W)) ad_port_i (
		.clk(pclk),
		.rstn(presetn),
		.other_reset(other_reset),
		.regs(d_if),
		.bus_sel(d_sel),
		.bus_out(bus_ad_out),
		.bus_oe({D_W{bus_ad_oe}}),
		.pin_in(ad_pin_in),
		.pin_out(ad_pin_out),
		.pin_oe_n(ad_pin_oe_n)
	);

	// five control pins, strobes are always driven when bus-owned
	io_port #(.W(G_W)) ctl_port_i (
		.clk(pclk),
		.rstn(presetn),
		.other_reset(other_reset),
		.regs(g_if),
		.bus_sel(g_sel),
		.bus_out(bus_ctl_out),
		.bus_oe({G_W{1'b1}}),
		.pin_in(ctl_pin_in),
		.pin_out(ctl_pin_out),
		.pin_oe_n(ctl_pin_oe_n)
	);

	// demultiplexed data port, used by the bus in 8-bit mode only
	io_port #(.W(J_W)) db_port_i (
		.clk(pclk),
		.rstn(presetn),
		.other_reset(other_reset),
		.regs(j_if),
		.bus_sel(j_sel),
		.bus_out(bus_data_out),
		.bus_oe({J_W{bus_data_oe}}),
		.pin_in(db_pin_in),
		.pin_out(db_pin_out),
		.pin_oe_n(db_pin_oe_n)
	);

	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign bus_ad_in = d_if.level;
	assign bus_data_in = j_if.level;
	assign program_select_bit = q.ebc[EBC_PGM_SEL_BIT];
	assign wait_states = q.ebc[EBC_WAIT_LSB +: 2];
	assign write_mode_select = q.ebc[EBC_WM_LSB +: 2];

	chk_wrh_freed: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_8bit_mode && !exec_internal) |-> (g_sel == 5'h17))
		else $error("high write strobe pin not freed in 8-bit external mode");
	chk_ctl_io_cause: assert property (@(posedge pclk) disable iff (!presetn)
		(g_sel == 5'h00) |-> (q.ebc[EBC_DISABLE_BIT] && exec_internal))
		else $error("control pins left the bus without cause");
	chk_data_8bit: assert property (@(posedge pclk) disable iff (!presetn)
		(|j_sel) |-> (bus_8bit_mode && !(q.ebc[EBC_DISABLE_BIT] && exec_internal)))
		else $error("data port on bus outside 8-bit mode");
	chk_reset_bus_on: assert property (@(posedge pclk) disable iff (!presetn)
		other_reset |=> (bus_on || !exec_internal) ##0 !q.ebc[EBC_DISABLE_BIT])
		else $error("bus disable not cleared by reset");
	chk_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !q.ready && !pwrite && paddr == OFF_D_PINS)
		|=> (pready && prdata == 32'($past(d_if.level))))
		else $error("pin register read does not return pin levels");
	chk_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !q.ready) |=> pready ##1 !pready)
		else $error("apb answer not after exactly one wait state");
endmodule : port_bus_pin_mux
`default_nettype wire

// ===== tb/ext_bus_model.sv
// behavioural far side of one port: external memory or board logic on the pins
`default_nettype none
module ext_bus_model #(parameter int W = 8) (
	input wire logic [W-1:0] pin_out, // device drive value
	input wire logic [W-1:0] pin_oe_n, // low while the device drives
	input wire logic [W-1:0] ext_val, // far side value, new on each step
	output logic [W-1:0] pin_in // resolved wire level
);
	// released bits show the far side's pattern, never the last driven value
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule : ext_bus_model
`default_nettype wire

// ===== tb/port_bus_pin_mux_tb.sv
// self-checking bench for the port and system bus pin multiplexer
`default_nettype none
module port_bus_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pin_mux_pkg::*;
	logic pclk = 0, presetn = 0, other_reset = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, bus_8bit_mode = 0, exec_internal = 0, bus_ad_oe = 1, bus_data_oe = 1;
	logic [7:0] bus_ad_out = 8'h5a, bus_data_out = 8'hc3, ad_in, db_in, ad_out, ad_oe_n, db_out, db_oe_n;
	logic [7:0] ext_d = 8'h00, ext_j = 8'h00, lat, dir, ext, m;
	logic [4:0] bus_ctl_out = 5'h15, ext_g = 5'h00, ctl_in, ctl_out, ctl_oe_n;
	logic [31:0] seed = 32'hd56e;
	logic psb;
	logic [1:0] ws, wms;
	logic [7:0] ad_lvl, db_lvl;
	int fails = 0, total_checks = 0;
	// 100 ns period
	always #50 pclk = ~pclk;
	port_bus_pin_mux i_dut (.pclk(pclk), .presetn(presetn), .other_reset(other_reset), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_8bit_mode(bus_8bit_mode), .exec_internal(exec_internal),
		.bus_ad_out(bus_ad_out), .bus_ad_oe(bus_ad_oe), .bus_ctl_out(bus_ctl_out),
		.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_ad_in(ad_lvl), .bus_data_in(db_lvl),
		.program_select_bit(psb), .wait_states(ws), .write_mode_select(wms), .ad_pin_in(ad_in),
		.ad_pin_out(ad_out), .ad_pin_oe_n(ad_oe_n), .ctl_pin_in(ctl_in), .ctl_pin_out(ctl_out),
		.ctl_pin_oe_n(ctl_oe_n), .db_pin_in(db_in), .db_pin_out(db_out), .db_pin_oe_n(db_oe_n));
	ext_bus_model #(.W(8)) i_ext_d (.pin_out(ad_out), .pin_oe_n(ad_oe_n), .ext_val(ext_d), .pin_in(ad_in));
	ext_bus_model #(.W(5)) i_ext_g (.pin_out(ctl_out), .pin_oe_n(ctl_oe_n), .ext_val(ext_g), .pin_in(ctl_in));
	ext_bus_model #(.W(8)) i_ext_j (.pin_out(db_out), .pin_oe_n(db_oe_n), .ext_val(ext_j), .pin_in(db_in));
	// xorshift source, fixed start so runs repeat
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] pout(int p);
		return (p == 0) ? ad_out : (p == 1) ? {3'h0, ctl_out} : db_out;
	endfunction : pout
	function automatic logic [7:0] poen(int p);
		return (p == 0) ? ad_oe_n : (p == 1) ? {3'h7, ctl_oe_n} : db_oe_n;
	endfunction : poen
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		#2000000;
		fails++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		// power-on: control and address/data pins serve the bus, 16-bit mode leaves data port io
		chk({ctl_oe_n, ctl_out}, {5'h00, bus_ctl_out});
		chk({ad_oe_n, ad_out}, {8'h00, bus_ad_out});
		chk(db_oe_n, 8'hff);
		apb(0, OFF_D_DIR, 0); chk(r, 32'hff);
		apb(0, OFF_G_DIR, 0); chk(r, 32'h1f);
		apb(0, OFF_J_DIR, 0); chk(r, 32'hff);
		apb(0, OFF_BUS_CTRL, 0); chk(r, 32'h0);
		// external program, 8-bit mode: data port joins the bus, high write strobe pin freed
		bus_8bit_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({db_oe_n, db_out}, {8'h00, bus_data_out});
		chk(ctl_oe_n, 5'h08);
		lat = 8'(rnd());
		apb(1, OFF_G_LAT, {24'h0, lat});
		apb(1, OFF_G_DIR, 32'h0);
		repeat (3) @(posedge pclk);
		chk({ctl_oe_n, ctl_out}, {5'h00, (bus_ctl_out & 5'h17) | (lat[4:0] & 5'h08)});
		apb(1, OFF_BUS_CTRL, 32'hff); chk(e, 1'b0);
		apb(0, OFF_BUS_CTRL, 0); chk(r, {24'h0, EBC_WRITE_MASK});
		chk({27'h0, psb, ws, wms}, 32'h1f);
		repeat (3) @(posedge pclk);
		chk(ctl_oe_n, 5'h00);
		bus_8bit_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(ctl_out, bus_ctl_out);
		// bus disabled and internal execution: every pin is io
		exec_internal <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			int p;
			p = i % 3;
			m = (p == 1) ? 8'h1f : 8'hff;
			lat = 8'(rnd());
			dir = 8'(rnd());
			ext = 8'(rnd());
			ext_d <= ext;
			ext_g <= ext[4:0];
			ext_j <= ext;
			apb(1, 12'(p * 12 + ((i < 3) ? 0 : 4)), {24'h0, lat});
			apb(1, 12'(p * 12 + 8), {24'h0, dir});
			repeat (6) @(posedge pclk);
			chk(poen(p) & m, dir & m);
			chk(pout(p) & ~dir & m, lat & ~dir & m);
			apb(0, 12'(p * 12 + 4), 0); chk(r, {24'h0, lat & m});
			apb(0, 12'(p * 12), 0); chk(r, {24'h0, ((lat & ~dir) | (ext & dir)) & m});
			// filtered levels towards the bus engine follow the same pins
			if (p != 1) chk((p == 0) ? ad_lvl : db_lvl, (lat & ~dir) | (ext & dir));
		end
		// bus back on: address/data pins serve the bus, data port latch kept, unmapped address errors
		exec_internal <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(ad_out, bus_ad_out);
		apb(0, OFF_J_LAT, 0); chk(r, {24'h0, lat});
		apb(0, 12'h028, 0); chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		// other reset: directions to ones, latches untouched
		@(posedge pclk);
		other_reset <= 1'b1;
		@(posedge pclk);
		other_reset <= 1'b0;
		apb(0, OFF_J_DIR, 0); chk(r, 32'hff);
		apb(0, OFF_J_LAT, 0); chk(r, {24'h0, lat});
		apb(0, OFF_BUS_CTRL, 0); chk(r, 32'h0);
		chk({27'h0, psb, ws, wms}, 32'h0);
		test_done();
	end
endmodule : port_bus_pin_mux_tb
`default_nettype wire
